// [shared/lsm_pkg.sv]
// Purpose: Shared constants and types for the configurable logic slice.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, word-aligned registers.
// Notes:   One slice of two four-input lookup tables with four operating modes.
// Operation
// R1: Slice runs in exactly one of logic, ripple, RAM or ROM mode.
// R2: Each four-input lookup holds a 16-entry truth table for any function.
// R3: Logic mode gives two four-input functions or one five-input function.
// R4: Ripple mode does 2-bit add, subtract, up count or down count.
// R5: Ripple mode compares A and B: greater-equal, not-equal, less-equal.
// R6: Fast carry configuration outputs carry generate and carry propagate; the slice drives them for add and subtract only, low for count and compare.
// R7: RAM mode makes each lookup 16x1, the slice a 16x2 single-port RAM.
// R8: Dual-port 16x2 RAM adds an independent read-only companion port.
// R9: ROM mode is RAM without write port, loaded only at configuration.
// R10: RAM writes on clock edge with write enable; reads are combinational.
`default_nettype none

package lsm_pkg;

   // ==========================================================
   // Register map
   localparam logic [3:0]  CTRL_OFS    = 4'h0;
   localparam logic [3:0]  LUT0_OFS    = 4'h4;
   localparam logic [3:0]  LUT1_OFS    = 4'h8;
   localparam logic [3:0]  STAT_OFS    = 4'hC;
   localparam int          MODE_LSB    = 0;
   localparam int          FIVE_BIT    = 2;
   localparam int          DUAL_BIT    = 3;
   localparam int          FCARRY_BIT  = 4;
   localparam int          ROP_LSB     = 8;
   localparam logic [15:0] CTRL_RST    = 16'h0000;
   localparam logic [15:0] LUT_RST     = 16'h0000;
   localparam logic [1:0]  CNT_RST     = 2'h0;

   // ==========================================================
   // Modes and ripple functions
   typedef enum logic [1:0] {
      LSM_LOGIC  = 2'h0,
      LSM_RIPPLE = 2'h1,
      LSM_RAM    = 2'h2,
      LSM_ROM    = 2'h3
   } lsm_mode_t;

   typedef enum logic [2:0] {
      ROP_ADD  = 3'h0,
      ROP_SUB  = 3'h1,
      ROP_UP   = 3'h2,
      ROP_DOWN = 3'h3,
      ROP_CMP  = 3'h4
   } lsm_rop_t;

   // ==========================================================
   // User-side carriers
   typedef struct packed {
      logic [3:0] a0;
      logic [3:0] a1;
      logic       in5;
      logic [1:0] op_a;
      logic [1:0] op_b;
      logic       cin;
      logic [3:0] addr;
      logic [1:0] wdata;
      logic       we;
      logic [3:0] dp_addr;
   } lsm_in_t;

   typedef struct packed {
      logic [1:0] cnt;
      logic [1:0] dp_rdata;
      logic       cprop;
      logic       cgen;
      logic       le;
      logic       ne;
      logic       ge;
      logic       cout;
      logic [1:0] f;
   } lsm_out_t;

endpackage : lsm_pkg

`default_nettype wire

// [hw/lsm_slice.sv]
// Purpose: Logic slice with logic, ripple, distributed RAM and ROM modes.
// Assumes: Registers over Avalon-MM; user inputs synchronous to core_clk.
// Notes:   Every bus access answers on its second cycle.
`timescale 1ns/1ns
`default_nettype none

module lsm_slice (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [3:0]        address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [3:0]        byteenable,
   input  wire logic [31:0]       writedata,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   input  wire lsm_pkg::lsm_in_t  usr_in,
   output lsm_pkg::lsm_out_t      usr_out
);
   import lsm_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic lut_bit(input logic [15:0] tbl,
                                    input logic [3:0] idx);
      lut_bit = tbl[idx];
   endfunction : lut_bit

   function automatic logic [15:0] be_merge(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : be_merge

   // ==========================================================
   // Bus slave
   logic        ack_reg;
   logic        wr_fire;
   logic [15:0] ctrl_reg;
   logic [15:0] lut0_reg;
   logic [15:0] lut1_reg;
   logic [1:0]  cnt_reg;
   logic [1:0]  cnt_next;
   logic [31:0] rdata_next;
   lsm_out_t    out_c;

   assign waitrequest = (read | write) & ~ack_reg;
   assign wr_fire     = write & ack_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   // Unmapped offsets read as zero and ignore writes
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (address)
         CTRL_OFS: rdata_next = {16'h0000, ctrl_reg};
         LUT0_OFS: rdata_next = {16'h0000, lut0_reg};
         LUT1_OFS: rdata_next = {16'h0000, lut1_reg};
         STAT_OFS: rdata_next = {20'h00000, out_c};
         default:  rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~ack_reg) begin
         readdata <= rdata_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr_fire && address == CTRL_OFS) begin
         ctrl_reg <= be_merge(ctrl_reg, writedata, byteenable);
      end
   end

   // ==========================================================
   // Configuration decode
   lsm_mode_t mode;
   lsm_rop_t  rop;
   logic      five_en;
   logic      dual_en;
   logic      fc_en;
   logic      is_logic;
   logic      is_rip;
   logic      is_ram;
   logic      is_rom;
   logic      cfg_lut_wr;

   assign mode     = lsm_mode_t'(ctrl_reg[MODE_LSB +: 2]);
   assign rop      = lsm_rop_t'(ctrl_reg[ROP_LSB +: 3]);
   assign five_en  = ctrl_reg[FIVE_BIT];
   assign dual_en  = ctrl_reg[DUAL_BIT];
   assign fc_en    = ctrl_reg[FCARRY_BIT];
   assign is_logic = (mode == LSM_LOGIC);  // R1
   assign is_rip   = (mode == LSM_RIPPLE);
   assign is_ram   = (mode == LSM_RAM);
   assign is_rom   = (mode == LSM_ROM);
   assign cfg_lut_wr = wr_fire && (address == LUT0_OFS || address == LUT1_OFS);

   // ==========================================================
   // Lookup table storage
   // Configuration writes win over a user write in the same cycle, since
   // loading contents is the configuration step and must not be corrupted.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lut0_reg <= LUT_RST;
         lut1_reg <= LUT_RST;
      end else if (wr_fire && address == LUT0_OFS) begin
         lut0_reg <= be_merge(lut0_reg, writedata, byteenable);  // R9
      end else if (wr_fire && address == LUT1_OFS) begin
         lut1_reg <= be_merge(lut1_reg, writedata, byteenable);
      end else if (is_ram && usr_in.we) begin  // R9
         lut0_reg[usr_in.addr] <= usr_in.wdata[0];  // R7 R10
         lut1_reg[usr_in.addr] <= usr_in.wdata[1];
      end
   end

   // ==========================================================
   // Ripple arithmetic
   logic [1:0] b_eff;
   logic [2:0] sum3;
   logic [2:0] gsum;
   logic       arith;

   assign arith = is_rip && (rop == ROP_ADD || rop == ROP_SUB);
   assign b_eff = (rop == ROP_SUB) ? ~usr_in.op_b : usr_in.op_b;
   // Subtract is A + ~B + cin: cin high means no borrow in
   assign sum3  = {1'b0, usr_in.op_a} + {1'b0, b_eff} + {2'b00, usr_in.cin};  // R4
   assign gsum  = {1'b0, usr_in.op_a} + {1'b0, b_eff};

   // Counter counts one step per cycle while cin is high
   always_comb begin
      cnt_next = cnt_reg;
      if (is_rip && usr_in.cin && rop == ROP_UP) begin
         cnt_next = cnt_reg + 2'h1;  // R4
      end else if (is_rip && usr_in.cin && rop == ROP_DOWN) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= CNT_RST;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ==========================================================
   // Output selection
   logic f5;

   assign f5 = usr_in.in5 ? lut_bit(lut1_reg, usr_in.a0)
                          : lut_bit(lut0_reg, usr_in.a0);  // R3

   always_comb begin
      out_c     = '0;
      out_c.cnt = cnt_reg;
      unique case (mode)
         LSM_LOGIC: begin
            if (five_en) begin
               out_c.f = {1'b0, f5};  // R3
            end else begin
               out_c.f = {lut_bit(lut1_reg, usr_in.a1),
                          lut_bit(lut0_reg, usr_in.a0)};  // R2
            end
         end
         LSM_RIPPLE: begin
            unique case (rop)
               ROP_ADD, ROP_SUB: begin
                  out_c.f    = sum3[1:0];
                  out_c.cout = sum3[2];
               end
               ROP_UP: begin
                  out_c.f    = cnt_reg;
                  out_c.cout = usr_in.cin & (cnt_reg == 2'h3);
               end
               ROP_DOWN: begin
                  out_c.f    = cnt_reg;
                  out_c.cout = usr_in.cin & (cnt_reg == 2'h0);
               end
               ROP_CMP: begin
                  out_c.ge = usr_in.op_a >= usr_in.op_b;  // R5
                  out_c.ne = usr_in.op_a != usr_in.op_b;
                  out_c.le = usr_in.op_a <= usr_in.op_b;
               end
               default: out_c.f = 2'h0;
            endcase
            // Group carry terms let a chain skip ripple through this slice
            if (fc_en && arith) begin
               out_c.cgen  = gsum[2];  // R6
               out_c.cprop = &(usr_in.op_a ^ b_eff);
            end
         end
         LSM_RAM, LSM_ROM: begin
            out_c.f = {lut_bit(lut1_reg, usr_in.addr),
                       lut_bit(lut0_reg, usr_in.addr)};  // R10
            if (is_ram && dual_en) begin
               out_c.dp_rdata = {lut_bit(lut1_reg, usr_in.dp_addr),
                                 lut_bit(lut0_reg, usr_in.dp_addr)};  // R8
            end
         end
      endcase
   end

   assign usr_out = out_c;

   // ==========================================================
   // Checks
   // Ripple flag and carry outputs stay low outside ripple mode, so no two modes act at once
   chk_mode_exclusive: assert property (@(posedge core_clk) disable iff (rst)  // R1
      !is_rip |-> {usr_out.cout, usr_out.ge, usr_out.ne, usr_out.le,
         usr_out.cgen, usr_out.cprop} == 6'h00)
      else $error("ripple outputs active outside ripple mode");

   chk_lut_four: assert property (@(posedge core_clk) disable iff (rst)  // R2
      is_logic && !five_en |->
         usr_out.f == {lut1_reg[usr_in.a1], lut0_reg[usr_in.a0]})
      else $error("four-input lookup output wrong");

   chk_lut_five: assert property (@(posedge core_clk) disable iff (rst)  // R3
      is_logic && five_en |-> usr_out.f[1] == 1'b0 &&
         usr_out.f[0] == (usr_in.in5 ? lut1_reg[usr_in.a0] : lut0_reg[usr_in.a0]))
      else $error("five-input lookup output wrong");

   chk_add_sum: assert property (@(posedge core_clk) disable iff (rst)  // R4
      is_rip && rop == ROP_ADD |->
         {usr_out.cout, usr_out.f} == usr_in.op_a + usr_in.op_b + usr_in.cin)
      else $error("ripple add result wrong");

   chk_down_count: assert property (@(posedge core_clk) disable iff (rst)  // R4
      is_rip && rop == ROP_DOWN && usr_in.cin |=>
         cnt_reg == $past(cnt_reg) - 2'h1)
      else $error("down counter did not step");

   chk_compare_out: assert property (@(posedge core_clk) disable iff (rst)  // R5
      is_rip && rop == ROP_CMP |-> usr_out.ge == (usr_in.op_a >= usr_in.op_b)
         && usr_out.le == (usr_in.op_a <= usr_in.op_b)
         && usr_out.ne == (usr_in.op_a != usr_in.op_b))
      else $error("compare flags wrong");

   chk_carry_gp: assert property (@(posedge core_clk) disable iff (rst)  // R6
      fc_en && arith |->
         usr_out.cout == (usr_out.cgen | (usr_out.cprop & usr_in.cin)))
      else $error("carry generate or propagate inconsistent");

   chk_ram_write: assert property (@(posedge core_clk) disable iff (rst)  // R7
      is_ram && usr_in.we && !cfg_lut_wr |=>
         {lut1_reg[$past(usr_in.addr)], lut0_reg[$past(usr_in.addr)]}
            == $past(usr_in.wdata))
      else $error("RAM write not stored");

   chk_dual_read: assert property (@(posedge core_clk) disable iff (rst)  // R8
      is_ram && dual_en |->
         usr_out.dp_rdata == {lut1_reg[usr_in.dp_addr], lut0_reg[usr_in.dp_addr]})
      else $error("companion read port wrong");

   chk_rom_hold: assert property (@(posedge core_clk) disable iff (rst)  // R9
      is_rom && !cfg_lut_wr |=> $stable(lut0_reg) && $stable(lut1_reg))
      else $error("ROM contents changed without configuration");

   chk_ram_read: assert property (@(posedge core_clk) disable iff (rst)  // R10
      is_ram |-> usr_out.f == {lut1_reg[usr_in.addr], lut0_reg[usr_in.addr]})
      else $error("RAM read not combinational");

   chk_sub_sum: assert property (@(posedge core_clk) disable iff (rst)  // R4
      is_rip && rop == ROP_SUB |-> {usr_out.cout, usr_out.f}
         == {1'b0, usr_in.op_a} + {1'b0, ~usr_in.op_b} + {2'b00, usr_in.cin})
      else $error("ripple subtract result wrong");

   chk_up_count: assert property (@(posedge core_clk) disable iff (rst)  // R4
      is_rip && rop == ROP_UP && usr_in.cin |=>
         cnt_reg == $past(cnt_reg) + 2'h1)
      else $error("up counter did not step");

   // The counter keeps its value across mode changes and idle cycles
   chk_count_idle: assert property (@(posedge core_clk) disable iff (rst)  // R4
      !(is_rip && usr_in.cin && (rop == ROP_UP || rop == ROP_DOWN)) |=>
         $stable(cnt_reg))
      else $error("counter moved without a count step");

   chk_dual_idle: assert property (@(posedge core_clk) disable iff (rst)  // R8
      !(is_ram && dual_en) |-> usr_out.dp_rdata == 2'h0)
      else $error("companion read port active outside dual-port RAM");

   chk_rom_read: assert property (@(posedge core_clk) disable iff (rst)  // R9
      is_rom |-> usr_out.f == {lut1_reg[usr_in.addr], lut0_reg[usr_in.addr]})
      else $error("ROM read wrong");

   chk_lut_load: assert property (@(posedge core_clk) disable iff (rst)  // R9
      wr_fire && address == LUT1_OFS && byteenable[1:0] == 2'h3 |=>
         lut1_reg == $past(writedata[15:0]))
      else $error("lookup contents not loaded");

   // Outside RAM mode only a configuration write may touch the tables
   chk_table_guard: assert property (@(posedge core_clk) disable iff (rst)  // R10
      !is_ram && !cfg_lut_wr |=> $stable(lut0_reg) && $stable(lut1_reg))
      else $error("lookup table changed outside RAM mode");

endmodule : lsm_slice

`default_nettype wire

// [verification/lsm_fabric.sv]
// Purpose: Model of the fabric user logic that feeds the slice user port.
// Assumes: The bench hands one command every two clocks.
// Notes:   Registered, so user inputs only ever move just after core_clk rises.
`timescale 1ns/1ns
`default_nettype none
module lsm_fabric (
   input  wire logic             core_clk,
   input  wire lsm_pkg::lsm_in_t cmd,
   output lsm_pkg::lsm_in_t      usr_in
);
   import lsm_pkg::*;
   always @(posedge core_clk) begin
      usr_in <= cmd;
   end
endmodule : lsm_fabric
`default_nettype wire

// [verification/lsm_slice_bench.sv]
// Purpose: Self-checking bench for the logic slice in all four modes.
// Assumes: Two-cycle register bus answer; user port fed through the fabric model.
// Notes:   Counter checks use step relations, since the count runs freely.
`timescale 1ns/1ns
`default_nettype none
module lsm_slice_bench;
   import lsm_pkg::*;
   logic        core_clk    = 1'b0;
   logic        rst         = 1'b1;
   logic [3:0]  address     = 4'h0;
   logic        read        = 1'b0;
   logic        write       = 1'b0;
   logic [3:0]  byteenable  = 4'hF;
   logic [31:0] writedata   = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   lsm_in_t     cmd         = '0;
   lsm_in_t     usr_in;
   lsm_out_t    usr_out;
   lsm_in_t     v;
   lsm_rop_t    op;
   int          n_errors    = 0;
   int          n_compared  = 0;
   int          cycles      = 0;
   logic [31:0] q;
   logic [15:0] l0, l1;
   logic [1:0]  e, b, c;
   logic [2:0]  s, g;

   always #5 core_clk = ~core_clk;

   lsm_fabric i_fab (.core_clk(core_clk), .cmd(cmd), .usr_in(usr_in));
   lsm_slice i_dut (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .usr_in(usr_in), .usr_out(usr_out));

   // ==========================================================
   // Shared tasks
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk

   // Request held until waitrequest is seen low; one idle edge follows
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge core_clk);
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, q);
   endtask : rd

   task automatic put(input lsm_in_t x);
      cmd <= x;
      repeat (2) @(posedge core_clk);
   endtask : put

   // ==========================================================
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   // ==========================================================
   // Tests
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(CTRL_OFS, 32'h0, "ctrl reset");
      rd(LUT1_OFS, 32'h0, "lut1 reset");
      bus(1'b1, LUT0_OFS, 32'hFFFF_A5C3);
      bus(1'b1, LUT1_OFS, 32'h0000_6996);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      rd(4'h2, 32'h0, "unmapped");
      rd(LUT0_OFS, 32'h0000_A5C3, "lut0 upper");
      $display("Test registers done");
      l0 = 16'hA5C3;
      l1 = 16'h6996;
      for (int i = 0; i < 64; i++) begin
         if (i[4:0] == 5'h0) bus(1'b1, CTRL_OFS, {29'h0, i[5], 2'h0});
         v = '0;
         v.a0 = i[3:0];
         v.a1 = ~i[3:0];
         v.in5 = i[4];
         put(v);
         if (i[5]) e = {1'b0, v.in5 ? l1[v.a0] : l0[v.a0]};
         else e = {l1[v.a1], l0[v.a0]};
         chk("logic f", {30'h0, e}, {30'h0, usr_out.f});
      end
      $display("Test logic done");
      for (int k = 0; k < 3; k++) begin
         op = (k == 2) ? ROP_CMP : lsm_rop_t'(k);
         bus(1'b1, CTRL_OFS, {21'h0, op, 3'h0, 1'b1, 2'h0, LSM_RIPPLE});
         for (int i = 0; i < 32; i++) begin
            v = '0;
            v.op_a = i[1:0];
            v.op_b = i[3:2];
            v.cin = i[4];
            put(v);
            b = (k == 1) ? ~v.op_b : v.op_b;
            s = {1'b0, v.op_a} + {1'b0, b} + {2'h0, v.cin};
            g = {1'b0, v.op_a} + {1'b0, b};
            if (k == 2) begin
               chk("compare", {29'h0, v.op_a >= v.op_b, v.op_a != v.op_b, v.op_a <= v.op_b},
                  {29'h0, usr_out.ge, usr_out.ne, usr_out.le});
            end else begin
               chk("sum", {29'h0, s}, {29'h0, usr_out.cout, usr_out.f});
               chk("gen prop", {30'h0, g[2], &(v.op_a ^ b)},
                  {30'h0, usr_out.cgen, usr_out.cprop});
            end
         end
      end
      for (int k = 2; k < 4; k++) begin
         bus(1'b1, CTRL_OFS, {21'h0, 3'(k), 8'h01});
         v = '0;
         v.cin = 1'b1;
         put(v);
         for (int i = 0; i < 6; i++) begin
            c = usr_out.cnt;
            chk("count out", {29'h0, c, (k == 2) ? c == 2'h3 : c == 2'h0},
               {29'h0, usr_out.f, usr_out.cout});
            @(posedge core_clk);
            chk("count step", {30'h0, (k == 2) ? c + 2'h1 : c - 2'h1},
               {30'h0, usr_out.cnt});
         end
      end
      put('0);
      $display("Test ripple done");
      bus(1'b1, CTRL_OFS, 32'h0000_000A);
      for (int i = 0; i < 32; i++) begin
         v = '0;
         v.addr = i[3:0];
         v.a0 = i[3:0];
         v.a1 = i[3:0];
         v.dp_addr = ~i[3:0];
         v.we = ~i[4];
         v.wdata = i[1:0] ^ 2'h1;
         put(v);
         if (i[4]) begin
            chk("ram read", {30'h0, i[1:0] ^ 2'h1}, {30'h0, usr_out.f});
            chk("dual read", {30'h0, ~i[1:0] ^ 2'h1}, {30'h0, usr_out.dp_rdata});
         end
      end
      rd(LUT0_OFS, 32'h0000_5555, "lut0 ram");
      rd(LUT1_OFS, 32'h0000_CCCC, "lut1 ram");
      $display("Test ram done");
      bus(1'b1, CTRL_OFS, 32'h0000_0003);
      rd(CTRL_OFS, 32'h0000_0003, "ctrl rom");
      v = '0;
      v.addr = 4'h6;
      v.a0 = 4'h6;
      v.a1 = 4'h6;
      v.we = 1'b1;
      v.wdata = 2'h0;
      put(v);
      @(posedge core_clk);
      chk("rom hold", 32'h3, {30'h0, usr_out.f});
      rd(LUT0_OFS, 32'h0000_5555, "rom lut0");
      // Counter bits are masked, the count runs freely in earlier tests
      bus(1'b0, STAT_OFS, 32'h0);
      chk("rom stat", 32'h0000_0003, q & 32'hFFFF_F3FF);
      $display("Test rom done");
      finish_test();
   end
endmodule : lsm_slice_bench
`default_nettype wire
